// ===== rtl/scpm_pkg.sv
// shared constants and types for the socket clock power management block
package scpm_pkg;

    // register byte offsets within the socket register space
    localparam logic [7:0]  SCPM_SOCKET_CTRL_OFS     = 8'h10;
    localparam logic [7:0]  SCPM_CLOCK_POWER_OFS     = 8'h20;

    // reset values of both registers
    localparam logic [31:0] SCPM_CLOCK_POWER_RESET   = 32'h0000_0000;
    localparam logic [31:0] SCPM_SOCKET_CTRL_RESET   = 32'h0000_0000;

    // field positions in the clock power control register
    localparam int          SCPM_ACCESS_SEEN_BIT     = 25;
    localparam int          SCPM_RATE_CHANGED_BIT    = 24;
    localparam int          SCPM_POLICY_ENABLE_BIT   = 16;
    localparam int          SCPM_IDLE_POLICY_BIT     = 0;

    // field position in the socket control register
    localparam int          SCPM_STOP_WO_HOST_BIT    = 7;

    // byte lanes that carry the writable bits
    localparam int          SCPM_LANE_POLICY_ENABLE  = 2;
    localparam int          SCPM_LANE_LOW            = 0;

    // slow mode divides the running card clock rate by this factor
    localparam int          SCPM_SLOW_DIVIDE         = 16;

    // idle cycles without card activity before the socket counts as idle
    localparam int          SCPM_IDLE_CYCLES_DEFAULT = 16;

    // reset value of the policy bit, also used while the policy is disabled
    localparam logic        SCPM_POLICY_RESET        = 1'b0;

    // requested behaviour of the card clock
    typedef enum logic [1:0] {
        CLK_RUN,
        CLK_SLOW,
        CLK_STOP
    } scpm_clk_mode_type;

    // clock run sequencing state
    typedef enum logic [0:0] {
        ST_ACTIVE,
        ST_REDUCED
    } scpm_state_type;

endpackage : scpm_pkg

// ===== rtl/scpm_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps

module scpm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] out;
    } scpm_sync_state_type;

    scpm_sync_state_type st_reg;
    scpm_sync_state_type st_next;

    // s1 feeds only s2; the output moves once s2 and s3 agree
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < W; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.out[i] = st_reg.s3[i];
            end
        end
    end

    // synchronous reset, all stages low
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.out;

endmodule : scpm_sync

// ===== rtl/scpm_clkdiv.sv
// card clock generator: full rate, divided by sixteen, or stopped low
`timescale 1ns/100ps

module scpm_clkdiv (
    input  wire logic                       clk,
    input  wire logic                       rstn,
    input  wire scpm_pkg::scpm_clk_mode_type mode,
    output logic                            card_clk
);

    localparam int          HALF_W    = $clog2(scpm_pkg::SCPM_SLOW_DIVIDE);
    localparam logic [HALF_W-1:0] HALF_LAST =
        HALF_W'(scpm_pkg::SCPM_SLOW_DIVIDE - 1);

    typedef struct packed {
        logic [HALF_W-1:0] cnt;
        logic              clk_q;
    } scpm_clkdiv_state_type;

    scpm_clkdiv_state_type st_reg;
    scpm_clkdiv_state_type st_next;

    // full rate toggles every cycle; slow toggles every sixteen cycles
    // stop lets a slow high phase end, so the card sees no runt pulse unless stop lands in that phase's first cycle
    always_comb begin
        st_next = st_reg;
        unique case (mode)
            scpm_pkg::CLK_RUN: begin
                st_next.cnt   = '0;
                st_next.clk_q = ~st_reg.clk_q;
            end
            scpm_pkg::CLK_SLOW: begin
                if (st_reg.cnt == HALF_LAST) begin
                    st_next.cnt   = '0;
                    st_next.clk_q = ~st_reg.clk_q;
                end else begin
                    st_next.cnt = st_reg.cnt + 1'b1;
                end
            end
            scpm_pkg::CLK_STOP: begin
                if (st_reg.clk_q && st_reg.cnt != HALF_LAST && st_reg.cnt != '0) begin
                    st_next.cnt = st_reg.cnt + 1'b1;  // finish a slow high phase
                end else begin
                    st_next.cnt   = '0;
                    st_next.clk_q = 1'b0;
                end
            end
            default: begin
                st_next.cnt   = '0;
                st_next.clk_q = 1'b0;
            end
        endcase
    end

    // synchronous reset, clock parked low
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign card_clk = st_reg.clk_q;

endmodule : scpm_clkdiv

// ===== rtl/scpm_top.sv
// socket clock power management register and card clock run control
`timescale 1ns/100ps

module scpm_top #(
    parameter int IDLE_CYCLES = scpm_pkg::SCPM_IDLE_CYCLES_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    // classic wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // socket side pins, asynchronous to clk
    input  wire logic        card_access_pin,
    input  wire logic        card_busy_pin,
    input  wire logic        host_clock_stop_pin,
    // card clock and its state
    output logic             card_clk,
    output logic             card_clock_reduced
);

    localparam int IW = $clog2(IDLE_CYCLES + 1);
    localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_CYCLES);

    // index of each synchronised input
    localparam int IN_ACCESS = 0;
    localparam int IN_BUSY   = 1;
    localparam int IN_HOST   = 2;

    // overview of the block
    // one bus-visible control register plus one socket control bit
    // the bus slave answers every taken request one cycle later
    // ack is a single-cycle pulse; a held strobe is taken again later
    // read data is captured with the ack and held until the next read
    // unmapped places ack normally, read zero and ignore writes
    // writes honour byte lanes, so a partial write leaves other bits alone
    // status bits ignore writes; only software-owned bits are stored

    // access status handling
    // the access pin is a level; each synced high cycle sets the flag
    // a read of the register clears the flag at its ack edge
    // the value returned still shows the flag as it was before the clear
    // an access landing in the clearing cycle wins, so none is lost
    // limitation: many accesses between reads collapse to one flag

    // idle tracking
    // activity is either the access pin or the busy pin, both synced
    // the socket counts as idle only after IDLE_CYCLES quiet cycles
    // the counter saturates, so a long idle stretch costs no extra logic
    // any activity clears the counter and restores full rate next edge
    // trade-off: a longer stretch delays savings but avoids clock flapping

    // clock run sequencing
    // two states: active runs the card clock, reduced stops or slows it
    // the reduced action is chosen from the enable and policy bits
    // a disabled policy falls back to stopping, the policy reset value
    // policy changes while reduced take effect on the next edge
    // the host request pin matters only while the socket bit is clear
    // the rate flag tracks the requested mode, not the divider phase

    typedef struct packed {
        logic                        ack;
        logic [31:0]                 rdata;
        logic                        clock_policy_enable;
        logic                        idle_clock_policy;
        logic                        idle_stop_without_host_request;
        logic                        card_access_seen;
        logic                        clock_rate_changed_flag;
        logic [IW-1:0]               idle_cnt;
        scpm_pkg::scpm_state_type    state;
        scpm_pkg::scpm_clk_mode_type mode;
    } scpm_top_state_type;

    scpm_top_state_type st_reg;
    scpm_top_state_type st_next;

    logic [2:0] pins_async;
    logic [2:0] pins_sync;

    // register hit decode, used by both the read and the write path
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction : hit

    // image of the clock power control register as software reads it
    function automatic logic [31:0] clock_power_image(input scpm_top_state_type s);
        logic [31:0] v;
        v = scpm_pkg::SCPM_CLOCK_POWER_RESET;
        v[scpm_pkg::SCPM_ACCESS_SEEN_BIT]   = s.card_access_seen;
        v[scpm_pkg::SCPM_RATE_CHANGED_BIT]  = s.clock_rate_changed_flag;
        v[scpm_pkg::SCPM_POLICY_ENABLE_BIT] = s.clock_policy_enable;
        v[scpm_pkg::SCPM_IDLE_POLICY_BIT]   = s.idle_clock_policy;
        clock_power_image = v;
    endfunction : clock_power_image

    // image of the socket control register; only the stop request bit lives here
    function automatic logic [31:0] socket_ctrl_image(input scpm_top_state_type s);
        logic [31:0] v;
        v = scpm_pkg::SCPM_SOCKET_CTRL_RESET;
        v[scpm_pkg::SCPM_STOP_WO_HOST_BIT] = s.idle_stop_without_host_request;
        socket_ctrl_image = v;
    endfunction : socket_ctrl_image

    // pins cross into clk through the filtered synchroniser
    assign pins_async[IN_ACCESS] = card_access_pin;
    assign pins_async[IN_BUSY]   = card_busy_pin;
    assign pins_async[IN_HOST]   = host_clock_stop_pin;

    scpm_sync #(
        .W        (3)
    ) u_sync (
        .clk      (clk),
        .rstn     (rstn),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    // next-state logic: bus slave, status flags, idle tracking, clock run sequencing
    always_comb begin
        logic                        req;
        logic                        wr;
        logic                        rd_status;
        logic                        card_activity;
        logic                        socket_idle;
        logic                        may_reduce;
        scpm_pkg::scpm_clk_mode_type idle_action;

        req           = 1'b0;
        wr            = 1'b0;
        rd_status     = 1'b0;
        card_activity = 1'b0;
        socket_idle   = 1'b0;
        may_reduce    = 1'b0;
        idle_action   = scpm_pkg::CLK_STOP;
        st_next       = st_reg;

        // one access per ack; ack drops the cycle after it was given
        req         = wb_cyc_i && wb_stb_i && !st_reg.ack;
        wr          = req && wb_we_i;
        st_next.ack = req;

        // read data is captured with the ack; unmapped reads return zero
        if (req && !wb_we_i) begin
            if (hit(wb_adr_i, scpm_pkg::SCPM_CLOCK_POWER_OFS)) begin
                st_next.rdata = clock_power_image(st_reg);
                rd_status     = 1'b1;
            end else if (hit(wb_adr_i, scpm_pkg::SCPM_SOCKET_CTRL_OFS)) begin
                st_next.rdata = socket_ctrl_image(st_reg);
            end else begin
                st_next.rdata = '0;
            end
        end

        // writes touch only writable bits, per byte lane; status bits ignore writes
        if (wr && hit(wb_adr_i, scpm_pkg::SCPM_CLOCK_POWER_OFS)) begin
            if (wb_sel_i[scpm_pkg::SCPM_LANE_POLICY_ENABLE]) begin
                st_next.clock_policy_enable =
                    wb_dat_i[scpm_pkg::SCPM_POLICY_ENABLE_BIT];
            end
            if (wb_sel_i[scpm_pkg::SCPM_LANE_LOW]) begin
                st_next.idle_clock_policy =
                    wb_dat_i[scpm_pkg::SCPM_IDLE_POLICY_BIT];
            end
        end
        if (wr && hit(wb_adr_i, scpm_pkg::SCPM_SOCKET_CTRL_OFS)) begin
            if (wb_sel_i[scpm_pkg::SCPM_LANE_LOW]) begin
                st_next.idle_stop_without_host_request =
                    wb_dat_i[scpm_pkg::SCPM_STOP_WO_HOST_BIT];
            end
        end

        // access flag: a new access in the clearing read's cycle survives the clear
        if (rd_status) begin
            st_next.card_access_seen = 1'b0;
        end
        if (pins_sync[IN_ACCESS]) begin
            st_next.card_access_seen = 1'b1;
        end

        // socket counts as idle after a quiet stretch, so short gaps do not flap the clock
        card_activity = pins_sync[IN_ACCESS] || pins_sync[IN_BUSY];
        if (card_activity) begin
            st_next.idle_cnt = '0;
        end else if (st_reg.idle_cnt != IDLE_LAST) begin
            st_next.idle_cnt = st_reg.idle_cnt + 1'b1;
        end
        socket_idle = !card_activity && (st_reg.idle_cnt == IDLE_LAST);

        // host stop request is only needed when the socket control bit is clear
        may_reduce = socket_idle &&
                     (st_reg.idle_stop_without_host_request ||
                      pins_sync[IN_HOST]);

        // disabled policy falls back to the stop action of the policy reset value
        if (st_reg.clock_policy_enable &&
            (st_reg.idle_clock_policy != scpm_pkg::SCPM_POLICY_RESET)) begin
            idle_action = scpm_pkg::CLK_SLOW;
        end else begin
            idle_action = scpm_pkg::CLK_STOP;
        end

        // activity restores full rate at once; policy changes apply while reduced
        unique case (st_reg.state)
            scpm_pkg::ST_ACTIVE: begin
                if (may_reduce) begin
                    st_next.state = scpm_pkg::ST_REDUCED;
                    st_next.mode  = idle_action;
                end else begin
                    st_next.mode  = scpm_pkg::CLK_RUN;
                end
            end
            scpm_pkg::ST_REDUCED: begin
                if (may_reduce) begin
                    st_next.mode  = idle_action;
                end else begin
                    st_next.state = scpm_pkg::ST_ACTIVE;
                    st_next.mode  = scpm_pkg::CLK_RUN;
                end
            end
        endcase

        // mode flag follows the clock request in the same edge
        st_next.clock_rate_changed_flag =
            (st_next.mode != scpm_pkg::CLK_RUN);
    end

    // state register notes
    // reset is synchronous, so every field is loaded on a clock edge
    // the register bits start at zero, matching the bus-visible default
    // mode starts at full rate so the card sees a running clock at once
    // the idle counter starts at zero, so idle needs a full quiet stretch
    // ack and read data start low so no stray answer follows reset
    // hazard: reset while a request is held withholds its ack until release
    // a request still held when reset is released is taken at the next edge
    // the pin synchroniser resets with the same signal, all stages low
    // so a pin that is high at release is seen four edges later
    // all state resets to the documented defaults
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_reg.ack                            <= 1'b0;
            st_reg.rdata                          <= '0;
            st_reg.clock_policy_enable            <= 1'b0;
            st_reg.idle_clock_policy              <= scpm_pkg::SCPM_POLICY_RESET;
            st_reg.idle_stop_without_host_request <= 1'b0;
            st_reg.card_access_seen               <= 1'b0;
            st_reg.clock_rate_changed_flag        <= 1'b0;
            st_reg.idle_cnt                       <= '0;
            st_reg.state                          <= scpm_pkg::ST_ACTIVE;
            st_reg.mode                           <= scpm_pkg::CLK_RUN;
        end else begin
            st_reg <= st_next;
        end
    end

    // card clock generation notes
    // the divider sees the registered mode, so it follows one edge later
    // full rate toggles every cycle, giving half the system clock rate
    // slow mode toggles every sixteen cycles, one sixteenth of full rate
    // stop parks the clock low but lets a slow high phase finish first
    // this avoids a runt high pulse that a card could miscount, except when stop lands in a slow high phase's first cycle
    // leaving stop or slow restarts full rate without waiting for a phase
    // limitation: the card clock is a register output, not a gated clock
    // card clock follows the registered mode
    scpm_clkdiv u_clkdiv (
        .clk      (clk),
        .rstn     (rstn),
        .mode     (st_reg.mode),
        .card_clk (card_clk)
    );

    assign wb_ack_o           = st_reg.ack;
    assign wb_dat_o           = st_reg.rdata;
    assign card_clock_reduced = st_reg.clock_rate_changed_flag;

endmodule : scpm_top

// ===== sim/scpm_card_model.sv
// behavioural card in the socket: drives activity pins, counts card clock edges
`timescale 1ns/100ps
module scpm_card_model (
    input  wire logic clk,
    input  wire logic card_clk,
    input  wire logic busy_req,
    input  wire logic access_req,
    output logic      card_busy_pin,
    output logic      card_access_pin,
    output int        rise_count
);
    // the card answers a bench request one clock later, like a real card
    initial begin
        card_busy_pin = 1'h1;
        card_access_pin = 1'h0;
        rise_count = 0;
    end
    always @(posedge clk) begin
        card_busy_pin <= busy_req;
        card_access_pin <= access_req;
    end
    // edge count lets the bench judge stop, slow and run rates
    always @(posedge card_clk) begin
        rise_count <= rise_count + 1;
    end
endmodule : scpm_card_model

// ===== sim/scpm_top_asserts.sv
// concurrent checks on the ports of the socket clock power management block
`timescale 1ns/100ps
module scpm_top_asserts #(
    parameter int IDLE_CYCLES = 16
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        card_access_pin,
    input wire logic        card_busy_pin,
    input wire logic        host_clock_stop_pin,
    input wire logic        card_clk,
    input wire logic        card_clock_reduced
);
    logic       en_reg, pol_reg, stop7_reg, slow, rd20;
    logic [5:0] slow_cnt_reg;
    // shadow of the policy bits; one cycle late, so windows below allow slack
    always_ff @(posedge clk) begin
        if (!rstn) begin
            en_reg <= 1'h0;
            pol_reg <= 1'h0;
            stop7_reg <= 1'h0;
        end else if (wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h08) begin
            if (wb_sel_i[2]) en_reg <= wb_dat_i[16];
            if (wb_sel_i[0]) pol_reg <= wb_dat_i[0];
        end else if (wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h04 && wb_sel_i[0]) begin
            stop7_reg <= wb_dat_i[7];
        end
    end
    // length of the current slow stretch, saturating
    always_ff @(posedge clk) begin
        if (!rstn || !slow) slow_cnt_reg <= 6'h0;
        else if (slow_cnt_reg != 6'h3F) slow_cnt_reg <= slow_cnt_reg + 6'h1;
    end
    assign slow = card_clock_reduced && en_reg && pol_reg;
    assign rd20 = wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h08;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    reserved_zero_a: assert property (rd20 |-> (wb_dat_o & 32'hFCFEFFFE) == 32'h0)
        else $error("reserved bits read nonzero");
    rate_flag_a: assert property (rd20 |-> wb_dat_o[24] == $past(card_clock_reduced))
        else $error("rate flag differs from reduced output");
    busy_blocks_a: assert property (card_busy_pin [*8] |-> !card_clock_reduced)
        else $error("clock reduced during card activity");
    access_blocks_a: assert property (card_access_pin [*8] |-> !card_clock_reduced)
        else $error("clock reduced during card access");
    host_gate_a: assert property ((!stop7_reg && !host_clock_stop_pin) [*8]
        |-> !card_clock_reduced) else $error("clock reduced without host request");
    stop_low_a: assert property (card_clock_reduced [*3] ##0 !slow |-> !card_clk)
        else $error("card clock not held low when stopped");
    run_toggle_a: assert property (!card_clock_reduced [*4] |=> $changed(card_clk))
        else $error("card clock not running at full rate");
    slow_period_a: assert property (slow_cnt_reg > 6'd40 && $changed(card_clk) |=>
        ($stable(card_clk) [*8] ##1 $stable(card_clk) [*7] ##1 $changed(card_clk))
        or (##[0:16] !card_clock_reduced)) else $error("slow clock period wrong");
endmodule : scpm_top_asserts

// ===== sim/test_scpm_top.sv
// self-checking bench for the socket clock power management block
`timescale 1ns/100ps
module test_scpm_top;
    localparam int IDLE = 2;
    logic        clk, rstn, wb_cyc, wb_stb, wb_we, wb_ack_o, host_stop, busy_req, acc_req;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat, wb_dat_o, rd;
    logic        card_access_pin, card_busy_pin, card_clk, card_clock_reduced;
    int          bad_count, tests_run, rises;

    scpm_top #(.IDLE_CYCLES(IDLE)) i_scpm_top (
        .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .card_access_pin(card_access_pin),
        .card_busy_pin(card_busy_pin), .host_clock_stop_pin(host_stop),
        .card_clk(card_clk), .card_clock_reduced(card_clock_reduced));
    scpm_card_model i_scpm_card_model (
        .clk(clk), .card_clk(card_clk), .busy_req(busy_req), .access_req(acc_req),
        .card_busy_pin(card_busy_pin), .card_access_pin(card_access_pin), .rise_count(rises));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // classic single cycle; request held until ack is sampled high
    task automatic bus(input logic we, input logic [7:0] a, input logic [3:0] s,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= s;
        wb_dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 16);
        rd = wb_dat_o;
        check("ack", {31'h0, wb_ack_o}, 32'h1);
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
    endtask : bus

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 4'hF, 32'h0);
        check($sformatf("reg %h", a), rd, e);
    endtask : rchk

    // reset value, read-only bits, byte lanes and an unmapped place
    task automatic t_regs();
        rchk(8'h20, 32'h0);
        bus(1'h1, 8'h20, 4'hF, 32'hFFFFFFFF);
        rchk(8'h20, 32'h00010001);
        bus(1'h1, 8'h20, 4'hB, 32'h0);
        rchk(8'h20, 32'h00010000);
        bus(1'h1, 8'hF0, 4'hF, 32'hFFFFFFFF);
        rchk(8'hF0, 32'h0);
        bus(1'h1, 8'h20, 4'hF, 32'h0);
        $display("test regs done");
    endtask : t_regs

    // access flag sets on card access and clears after one read
    task automatic t_access();
        acc_req <= 1'h1;
        repeat (4) @(posedge clk);
        acc_req <= 1'h0;
        repeat (8) @(posedge clk);
        rchk(8'h20, 32'h02000000);
        rchk(8'h20, 32'h0);
        $display("test access done");
    endtask : t_access

    // idle period under a given policy, then activity brings the clock back
    task automatic t_idle(input logic [31:0] pol, input logic s7, input logic host,
                          input logic [31:0] exp_rises, input logic [31:0] flag);
        int r0;
        bus(1'h1, 8'h10, 4'hF, {24'h0, s7, 7'h0});
        bus(1'h1, 8'h20, 4'hF, pol);
        host_stop <= host;
        busy_req <= 1'h0;
        repeat (40) @(posedge clk);
        r0 = rises;
        repeat (64) @(posedge clk);
        check("idle rises", 32'(rises - r0), exp_rises);
        rchk(8'h20, pol | flag);
        check("reduced out", {31'h0, card_clock_reduced}, {31'h0, flag[24]});
        busy_req <= 1'h1;
        repeat (12) @(posedge clk);
        rchk(8'h20, pol);
        check("reduced off", {31'h0, card_clock_reduced}, 32'h0);
        r0 = rises;
        repeat (64) @(posedge clk);
        check("run rises", 32'(rises - r0), 32'h20);
        host_stop <= 1'h0;
        $display("test idle %h done", pol);
    endtask : t_idle

    // free-running bench clock
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    // main sequence; synchronous reset clears the pin synchronisers at the first clock edge
    initial begin
        rstn = 1'h0;
        wb_cyc = 1'h0;
        wb_stb = 1'h0;
        wb_we = 1'h0;
        wb_adr = 8'h0;
        wb_sel = 4'h0;
        wb_dat = 32'h0;
        host_stop = 1'h0;
        busy_req = 1'h1;
        acc_req = 1'h0;
        bad_count = 0;
        tests_run = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        t_regs();
        t_access();
        t_idle(32'h0, 1'h1, 1'h0, 32'h0, 32'h01000000);
        t_idle(32'h1, 1'h1, 1'h0, 32'h0, 32'h01000000);
        t_idle(32'h00010000, 1'h1, 1'h0, 32'h0, 32'h01000000);
        t_idle(32'h00010001, 1'h1, 1'h0, 32'h2, 32'h01000000);
        t_idle(32'h0, 1'h0, 1'h0, 32'h20, 32'h0);
        t_idle(32'h00010001, 1'h0, 1'h1, 32'h2, 32'h01000000);
        give_verdict();
    end
    // watchdog, well beyond the roughly 1200 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
endmodule : test_scpm_top

bind scpm_top scpm_top_asserts #(.IDLE_CYCLES(IDLE_CYCLES)) i_scpm_top_asserts (
    .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .card_access_pin(card_access_pin), .card_busy_pin(card_busy_pin),
    .host_clock_stop_pin(host_clock_stop_pin), .card_clk(card_clk),
    .card_clock_reduced(card_clock_reduced));
